// ===== fpmd_checker.sv
// port assertions for the front-panel message display
`timescale 1ns/1ps
module fpmd_checker #(
	parameter logic [39:0] TIMEOUT_CYCLES = 40'h32,
	parameter logic [39:0] BLINK_CYCLES = 40'h8
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic key_valid,
	input wire logic [4:0] key_code,
	input wire logic init_busy,
	input wire logic trip_event,
	input wire logic fail_event,
	input wire logic warn_event,
	input wire logic [127:0] disp_text,
	input wire logic [31:0] disp_level,
	input wire logic nv_trip_save,
	input wire logic nv_trip_erase
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// no event of any kind; trip shown when position 15 is at full level
	wire calm = !key_valid && !trip_event && !fail_event && !warn_event;
	wire is_trip = disp_level[1:0] == fpmd_pkg::LVL_MAX;
	wire no_ev = !trip_event && !fail_event && !warn_event && !init_busy;
	sequence s_quiet;
		calm && !init_busy;
	endsequence
	sequence s_trip_key;
		s_quiet[*2] ##1 (key_valid && is_trip && no_ev);
	endsequence
	a_save_after_trip: assert property ((trip_event && !init_busy) |=> nv_trip_save) else $error("no save after trip");
	a_save_single: assert property (nv_trip_save |=> !nv_trip_save) else $error("save pulse too long");
	a_trip_shown: assert property ((trip_event && !init_busy) ##1 calm |=> disp_text[127:96] == "TRIP"
		&& disp_level == {16{fpmd_pkg::LVL_MAX}}) else $error("trip line wrong");
	a_erase_on_key: assert property (s_trip_key |=> nv_trip_erase) else $error("no erase after key");
	a_key_clears: assert property (s_trip_key ##1 calm |=> disp_level == 32'h0
		&& disp_text == {16{fpmd_pkg::CH_SPACE}}) else $error("trip not removed");
	a_erase_single: assert property (nv_trip_erase |=> !nv_trip_erase) else $error("erase pulse too long");
	a_fail_shown: assert property (s_quiet[*2] ##1 (fail_event && !trip_event && !is_trip && !init_busy) ##1 calm
		|=> disp_text[127:96] == "FAIL" && disp_level == {16{fpmd_pkg::LVL_HALF}}) else $error("fail line wrong");
	// a warning is only taken when neither trip nor fail is on show
	a_warn_shown: assert property (s_quiet[*2] ##1 (warn_event && !trip_event && !fail_event && !is_trip
		&& disp_text[127:96] != "FAIL" && !init_busy) ##1 calm
		|=> disp_text[127:96] == "WARN" && disp_level == {16{fpmd_pkg::LVL_HALF}}) else $error("warn line wrong");
	a_init_shown: assert property ((init_busy && !trip_event)[*3] |-> disp_text == "  INITIALIZING  "
		&& disp_level == {16{fpmd_pkg::LVL_HALF}}) else $error("init line wrong");
	a_digit_dim: assert property (s_quiet[*2] ##1 (key_valid && key_code <= fpmd_pkg::KEY_DIGIT_MAX && no_ev
		&& disp_level == 32'h0) ##1 calm |=> disp_text[7:0] == fpmd_pkg::CH_ZERO + {3'h0, $past(key_code, 2)}
		&& disp_level[1:0] == fpmd_pkg::LVL_DIM) else $error("digit echo wrong");
endmodule // fpmd_checker

bind fpmd_display fpmd_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES), .BLINK_CYCLES(BLINK_CYCLES)) u_chk (
	.sys_clk(sys_clk), .reset(reset), .key_valid(key_valid), .key_code(key_code),
	.init_busy(init_busy), .trip_event(trip_event), .fail_event(fail_event), .warn_event(warn_event),
	.disp_text(disp_text), .disp_level(disp_level), .nv_trip_save(nv_trip_save), .nv_trip_erase(nv_trip_erase));

// ===== fpmd_display.sv
// front-panel message display controller: key echo, notices, brightness, blanking
`timescale 1ns/1ps
module fpmd_display #(
	parameter logic [fpmd_pkg::TIMER_W-1:0] TIMEOUT_CYCLES = fpmd_pkg::TIMER_W'(fpmd_pkg::TIMEOUT_CYC),
	parameter logic [fpmd_pkg::TIMER_W-1:0] BLINK_CYCLES = fpmd_pkg::TIMER_W'(fpmd_pkg::BLINK_CYC)
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic key_valid,
	input wire logic [fpmd_pkg::KEY_W-1:0] key_code,
	input wire logic init_busy,
	input wire logic trip_event,
	input wire logic [23:0] trip_fault_type,
	input wire logic [23:0] trip_kind,
	input wire logic [11:0] trip_dist_bcd,
	input wire logic nv_trip_valid,
	input wire logic fail_event,
	input wire logic [11:0] fail_code_bcd,
	input wire logic warn_event,
	input wire logic [11:0] warn_code_bcd,
	output logic [fpmd_pkg::DISP_CHARS*fpmd_pkg::CHAR_W-1:0] disp_text,
	output logic [fpmd_pkg::DISP_CHARS*fpmd_pkg::LEVEL_W-1:0] disp_level,
	output logic nv_trip_save,
	output logic nv_trip_erase
);
	localparam int LINE_W = fpmd_pkg::DISP_CHARS * fpmd_pkg::CHAR_W;
	localparam int LVL_LINE_W = fpmd_pkg::DISP_CHARS * fpmd_pkg::LEVEL_W;
	localparam int HALF_W = LINE_W / 2;

	fpmd_timer_if idle_tif();
	fpmd_timer_if blink_tif();

	fpmd_timer #(.INTERVAL(TIMEOUT_CYCLES)) u_idle_timer (
		.sys_clk(sys_clk),
		.reset(reset),
		.tif(idle_tif.timer)
	);

	fpmd_timer #(.INTERVAL(BLINK_CYCLES)) u_blink_timer (
		.sys_clk(sys_clk),
		.reset(reset),
		.tif(blink_tif.timer)
	);

	// three bcd digits to ascii
	function automatic logic [23:0] fpmd_bcd3(input logic [11:0] bcd);
		fpmd_bcd3 = {fpmd_pkg::CH_ZERO + {4'h0, bcd[11:8]},
			fpmd_pkg::CH_ZERO + {4'h0, bcd[7:4]},
			fpmd_pkg::CH_ZERO + {4'h0, bcd[3:0]}};
	endfunction

	// abbreviated word shown for a function key
	function automatic logic [HALF_W-1:0] fpmd_word(input logic [fpmd_pkg::KEY_W-1:0] code);
		case (code)
			fpmd_pkg::KEY_DASH: fpmd_word = "SPARE   ";
			fpmd_pkg::KEY_UP: fpmd_word = "NEXT    ";
			fpmd_pkg::KEY_DOWN: fpmd_word = "PREV    ";
			fpmd_pkg::KEY_SET: fpmd_word = "SET     ";
			fpmd_pkg::KEY_ACT: fpmd_word = "ACT     ";
			fpmd_pkg::KEY_INF: fpmd_word = "INF     ";
			fpmd_pkg::KEY_END: fpmd_word = "END     ";
			default: fpmd_word = "KEY     ";
		endcase
	endfunction

	fpmd_pkg::fpmd_mode_t mode_reg, mode_next;
	logic [HALF_W-1:0] word_reg, word_next;
	logic [HALF_W-1:0] entry_reg, entry_next;
	logic [3:0] entry_len_reg, entry_len_next;
	logic entry_stored_reg, entry_stored_next;
	logic [LINE_W-1:0] notice_reg, notice_next;
	logic init_prev_reg, init_prev_next;
	logic blink_on_reg, blink_on_next;
	logic nv_save_reg, nv_save_next;
	logic nv_erase_reg, nv_erase_next;
	logic [LINE_W-1:0] text_reg, text_next;
	logic [LVL_LINE_W-1:0] level_reg, level_next;
	logic [LINE_W-1:0] trip_line;
	logic notice_mode;

	// trip text built from the record, also used when restoring after restart
	assign trip_line = {"TRIP", fpmd_pkg::CH_SPACE, trip_fault_type, fpmd_pkg::CH_SPACE, trip_kind,
		fpmd_pkg::CH_SPACE, fpmd_bcd3(trip_dist_bcd)};

	assign notice_mode = (mode_reg == fpmd_pkg::FPMD_TRIP) || (mode_reg == fpmd_pkg::FPMD_FAIL)
		|| (mode_reg == fpmd_pkg::FPMD_WARN);

	// idle timer runs only on key-driven content and restarts with each key
	assign idle_tif.run = (mode_reg == fpmd_pkg::FPMD_KEY) && !notice_mode;
	assign idle_tif.restart = key_valid;
	assign blink_tif.run = 1'b1;
	assign blink_tif.restart = trip_event;

	// mode sequencing: init, then events, then keys; a trip outranks a key, as does a fail or warning not blocked by a higher notice
	always_comb begin
		mode_next = mode_reg;
		word_next = word_reg;
		entry_next = entry_reg;
		entry_len_next = entry_len_reg;
		entry_stored_next = entry_stored_reg;
		notice_next = notice_reg;
		init_prev_next = init_busy;
		blink_on_next = blink_on_reg;
		nv_save_next = 1'b0;
		nv_erase_next = 1'b0;
		if (blink_tif.expired) begin
			blink_on_next = !blink_on_reg;
		end
		if (init_busy) begin
			mode_next = fpmd_pkg::FPMD_INIT;
		end else if (init_prev_reg && nv_trip_valid && !trip_event) begin
			// a fresh trip at init end must fall through, or it would never be saved
			mode_next = fpmd_pkg::FPMD_TRIP;
			notice_next = trip_line;
			blink_on_next = 1'b1;
		end else if (init_prev_reg && !trip_event && !fail_event && !warn_event) begin
			mode_next = fpmd_pkg::FPMD_BLANK;
		end else if (trip_event) begin
			mode_next = fpmd_pkg::FPMD_TRIP;
			notice_next = trip_line;
			blink_on_next = 1'b1;
			nv_save_next = 1'b1;
		end else if (fail_event && mode_reg != fpmd_pkg::FPMD_TRIP) begin
			mode_next = fpmd_pkg::FPMD_FAIL;
			notice_next = {"FAIL", fpmd_pkg::CH_SPACE, fpmd_bcd3(fail_code_bcd), "        "};
		end else if (warn_event && mode_reg != fpmd_pkg::FPMD_TRIP && mode_reg != fpmd_pkg::FPMD_FAIL) begin
			mode_next = fpmd_pkg::FPMD_WARN;
			notice_next = {"WARN", fpmd_pkg::CH_SPACE, fpmd_bcd3(warn_code_bcd), "        "};
		end else if (key_valid && notice_mode) begin
			// a key removes the notice and is consumed by that removal
			mode_next = fpmd_pkg::FPMD_BLANK;
			nv_erase_next = (mode_reg == fpmd_pkg::FPMD_TRIP);
		end else if (key_valid) begin
			mode_next = fpmd_pkg::FPMD_KEY;
			if (key_code <= fpmd_pkg::KEY_DIGIT_MAX || key_code == fpmd_pkg::KEY_POINT) begin
				// digits shift in from the right; older ones scroll off the left
				entry_next = {entry_reg[HALF_W-fpmd_pkg::CHAR_W-1:0], (key_code == fpmd_pkg::KEY_POINT) ?
					fpmd_pkg::CH_POINT : fpmd_pkg::CH_ZERO + {4'h0, key_code[3:0]}};
				if (entry_stored_reg) begin
					entry_next = {"       ", (key_code == fpmd_pkg::KEY_POINT) ?
						fpmd_pkg::CH_POINT : fpmd_pkg::CH_ZERO + {4'h0, key_code[3:0]}};
				end
				entry_stored_next = 1'b0;
				if (entry_stored_reg) begin
					entry_len_next = 4'h1;
				end else if (entry_len_reg != fpmd_pkg::ENTRY_LEN_MAX) begin
					entry_len_next = entry_len_reg + 4'h1;
				end
			end else if (key_code == fpmd_pkg::KEY_ENTER) begin
				// enter shows STORED over pending input, otherwise ENTERED with the entry cleared
				if (entry_len_reg != 4'h0 && !entry_stored_reg) begin
					word_next = "STORED  ";
					entry_stored_next = 1'b1;
				end else begin
					word_next = "ENTERED ";
					entry_next = "        ";
					entry_len_next = 4'h0;
					entry_stored_next = 1'b0;
				end
			end else if (key_code == fpmd_pkg::KEY_CLEAR) begin
				if (entry_len_reg != 4'h0 && !entry_stored_reg) begin
					entry_next = "        ";
					entry_len_next = 4'h0;
				end else begin
					mode_next = fpmd_pkg::FPMD_BLANK;
				end
			end else begin
				word_next = fpmd_word(key_code);
				entry_next = "        ";
				entry_len_next = 4'h0;
				entry_stored_next = 1'b0;
			end
		end else if (mode_reg == fpmd_pkg::FPMD_KEY && idle_tif.expired) begin
			mode_next = fpmd_pkg::FPMD_BLANK;
		end
		// a blank display forgets the key-driven text
		if (mode_next == fpmd_pkg::FPMD_BLANK) begin
			word_next = "        ";
			entry_next = "        ";
			entry_len_next = 4'h0;
			entry_stored_next = 1'b0;
		end
	end

	// compose the registered line; position 0 is leftmost, in the top byte
	always_comb begin
		text_next = {fpmd_pkg::DISP_CHARS{fpmd_pkg::CH_SPACE}};
		level_next = {fpmd_pkg::DISP_CHARS{fpmd_pkg::LVL_OFF}};
		case (mode_reg)
			fpmd_pkg::FPMD_INIT: begin
				text_next = "  INITIALIZING  ";
				level_next = {fpmd_pkg::DISP_CHARS{fpmd_pkg::LVL_HALF}};
			end
			fpmd_pkg::FPMD_TRIP: begin
				text_next = notice_reg;
				level_next = {fpmd_pkg::DISP_CHARS{fpmd_pkg::LVL_MAX}};
				for (int i = 0; i < fpmd_pkg::TRIP_WORD_CHARS; i++) begin
					if (!blink_on_reg) begin
						level_next[LVL_LINE_W-1-fpmd_pkg::LEVEL_W*i -: fpmd_pkg::LEVEL_W] = fpmd_pkg::LVL_OFF;
					end
				end
			end
			fpmd_pkg::FPMD_FAIL, fpmd_pkg::FPMD_WARN: begin
				text_next = notice_reg;
				level_next = {fpmd_pkg::DISP_CHARS{fpmd_pkg::LVL_HALF}};
			end
			fpmd_pkg::FPMD_KEY: begin
				text_next = {word_reg, entry_reg};
				level_next = {{fpmd_pkg::ENTRY_CHARS{fpmd_pkg::LVL_HALF}},
					{fpmd_pkg::ENTRY_CHARS{entry_stored_reg ? fpmd_pkg::LVL_HALF : fpmd_pkg::LVL_DIM}}};
			end
			default: begin
				text_next = {fpmd_pkg::DISP_CHARS{fpmd_pkg::CH_SPACE}};
			end
		endcase
	end

	// register stage for all state and the outputs
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			mode_reg <= fpmd_pkg::FPMD_BLANK;
			word_reg <= "        ";
			entry_reg <= "        ";
			entry_len_reg <= 4'h0;
			entry_stored_reg <= 1'b0;
			notice_reg <= {fpmd_pkg::DISP_CHARS{fpmd_pkg::CH_SPACE}};
			init_prev_reg <= 1'b0;
			blink_on_reg <= 1'b1;
			nv_save_reg <= 1'b0;
			nv_erase_reg <= 1'b0;
			text_reg <= {fpmd_pkg::DISP_CHARS{fpmd_pkg::CH_SPACE}};
			level_reg <= {fpmd_pkg::DISP_CHARS{fpmd_pkg::LVL_OFF}};
		end else begin
			mode_reg <= mode_next;
			word_reg <= word_next;
			entry_reg <= entry_next;
			entry_len_reg <= entry_len_next;
			entry_stored_reg <= entry_stored_next;
			notice_reg <= notice_next;
			init_prev_reg <= init_prev_next;
			blink_on_reg <= blink_on_next;
			nv_save_reg <= nv_save_next;
			nv_erase_reg <= nv_erase_next;
			text_reg <= text_next;
			level_reg <= level_next;
		end
	end

	assign disp_text = text_reg;
	assign disp_level = level_reg;
	assign nv_trip_save = nv_save_reg;
	assign nv_trip_erase = nv_erase_reg;
endmodule // fpmd_display

// ===== fpmd_panel_model.sv
// keypad driver and nonvolatile trip store facing the display
`timescale 1ns/1ps
module fpmd_panel_model (
	input wire logic sys_clk,
	input wire logic nv_trip_save,
	input wire logic nv_trip_erase,
	output logic nv_trip_valid,
	output logic key_valid,
	output logic [4:0] key_code
);
	// idle keypad, empty store
	initial begin
		nv_trip_valid = 1'b0;
		key_valid = 1'b0;
		key_code = 5'h1f;
	end
	// retained copy has no reset: it must outlive restarts
	always @(posedge sys_clk) begin
		if (nv_trip_erase) begin
			nv_trip_valid <= 1'b0;
		end else if (nv_trip_save) begin
			nv_trip_valid <= 1'b1;
		end
	end
	// one press lasts one clock; the code is scrambled afterwards
	task press(input logic [4:0] code);
		key_valid = 1'b1;
		key_code = code;
		@(posedge sys_clk);
		#1;
		key_valid = 1'b0;
		key_code = ~code; // stale code never lingers
	endtask
endmodule // fpmd_panel_model

// ===== fpmd_pkg.sv
// constants, key codes and display modes of the front-panel message display
package fpmd_pkg;
	localparam int DISP_CHARS = 16;
	localparam int CHAR_W = 8;
	localparam int LEVEL_W = 2;
	localparam int KEY_W = 5;
	localparam int TIMER_W = 40;

	// keypad codes presented on key_code
	localparam logic [4:0] KEY_DIGIT_MAX = 5'h09;
	localparam logic [4:0] KEY_POINT = 5'h0a;
	localparam logic [4:0] KEY_CLEAR = 5'h0b;
	localparam logic [4:0] KEY_DASH = 5'h0c;
	localparam logic [4:0] KEY_UP = 5'h0d;
	localparam logic [4:0] KEY_DOWN = 5'h0e;
	localparam logic [4:0] KEY_ENTER = 5'h0f;
	localparam logic [4:0] KEY_SET = 5'h10;
	localparam logic [4:0] KEY_ACT = 5'h11;
	localparam logic [4:0] KEY_INF = 5'h12;
	localparam logic [4:0] KEY_END = 5'h13;

	// per-position brightness codes
	localparam logic [1:0] LVL_OFF = 2'h0;
	localparam logic [1:0] LVL_DIM = 2'h1;
	localparam logic [1:0] LVL_HALF = 2'h2;
	localparam logic [1:0] LVL_MAX = 2'h3;

	localparam logic [7:0] CH_SPACE = 8'h20;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_POINT = 8'h2e;
	localparam int TRIP_WORD_CHARS = 4;
	localparam int ENTRY_CHARS = 8;
	localparam logic [3:0] ENTRY_LEN_MAX = 4'h8;

	// timing
	localparam longint CLK_HZ = 250_000_000;
	localparam longint TIMEOUT_MIN = 15;
	localparam longint BLINK_HALF_MS = 500;
	localparam longint TIMEOUT_CYC = TIMEOUT_MIN * 60 * CLK_HZ;
	localparam longint BLINK_CYC = BLINK_HALF_MS * CLK_HZ / 1000;

	typedef enum logic [2:0] {
		FPMD_BLANK,
		FPMD_INIT,
		FPMD_TRIP,
		FPMD_FAIL,
		FPMD_WARN,
		FPMD_KEY
	} fpmd_mode_t;
endpackage

// ===== fpmd_timer.sv
// interval timer, gated by run and restart, that pulses on expiry and reloads
`timescale 1ns/1ps
module fpmd_timer #(
	parameter logic [fpmd_pkg::TIMER_W-1:0] INTERVAL = 40'h00000003e8
) (
	input wire logic sys_clk,
	input wire logic reset,
	fpmd_timer_if.timer tif
);
	logic [fpmd_pkg::TIMER_W-1:0] count_reg, count_next;
	logic expired_reg, expired_next;

	// count held at zero while stopped, so a resumed interval starts whole
	always_comb begin
		count_next = count_reg;
		expired_next = 1'b0;
		if (tif.restart || !tif.run) begin
			count_next = '0;
		end else if (count_reg >= INTERVAL - 1'b1) begin
			count_next = '0;
			expired_next = 1'b1;
		end else begin
			count_next = count_reg + 1'b1;
		end
	end

	// register stage
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			count_reg <= '0;
			expired_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			expired_reg <= expired_next;
		end
	end

	assign tif.expired = expired_reg;
endmodule // fpmd_timer

// ===== fpmd_timer_if.sv
// control and expiry signals between the display core and an interval timer
`timescale 1ns/1ps
interface fpmd_timer_if;
	logic restart;
	logic run;
	logic expired;
	modport owner (output restart, output run, input expired);
	modport timer (input restart, input run, output expired);
endinterface // fpmd_timer_if

// ===== test_fpmd_display.sv
// self-checking bench for the front-panel message display
`timescale 1ns/1ps
module test_fpmd_display;
	localparam logic [39:0] TMO = 40'h32;
	localparam logic [39:0] BLK = 40'h8;
	localparam logic [127:0] TRIP_LINE = "TRIP BCG ZN1 123";
	localparam logic [127:0] BLANK = {16{fpmd_pkg::CH_SPACE}};
	localparam logic [31:0] HALF = {16{fpmd_pkg::LVL_HALF}};
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic init_busy = 1'b1;
	logic trip_event = 1'b0;
	logic fail_event = 1'b0;
	logic warn_event = 1'b0;
	logic [11:0] fail_code_bcd = 12'h042;
	logic [11:0] warn_code_bcd = 12'h007;
	logic key_valid, nv_trip_valid, nv_trip_save, nv_trip_erase;
	logic [4:0] key_code;
	logic [127:0] disp_text;
	logic [31:0] disp_level;
	int n_errors = 0;
	int samples_checked = 0;
	// 250 MHz
	always #2 sys_clk = ~sys_clk;
	fpmd_display #(.TIMEOUT_CYCLES(TMO), .BLINK_CYCLES(BLK)) dut (
		.sys_clk(sys_clk), .reset(reset), .key_valid(key_valid), .key_code(key_code), .init_busy(init_busy),
		.trip_event(trip_event), .trip_fault_type("BCG"), .trip_kind("ZN1"), .trip_dist_bcd(12'h123),
		.nv_trip_valid(nv_trip_valid), .fail_event(fail_event), .fail_code_bcd(fail_code_bcd),
		.warn_event(warn_event), .warn_code_bcd(warn_code_bcd), .disp_text(disp_text),
		.disp_level(disp_level), .nv_trip_save(nv_trip_save), .nv_trip_erase(nv_trip_erase));
	fpmd_panel_model u_panel (.sys_clk(sys_clk), .nv_trip_save(nv_trip_save), .nv_trip_erase(nv_trip_erase),
		.nv_trip_valid(nv_trip_valid), .key_valid(key_valid), .key_code(key_code));
	// inputs move 1 ns after the edge
	task step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task chk(input logic [127:0] seen, input logic [127:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task key(input logic [4:0] c);
		u_panel.press(c);
		step(2);
	endtask
	// reset then power-up initialization
	task restart;
		reset = 1'b1;
		init_busy = 1'b1;
		step(4);
		reset = 1'b0;
		step(4);
		chk(disp_text, "  INITIALIZING  ");
		chk(disp_level, HALF);
		init_busy = 1'b0;
		step(3);
	endtask
	task t_keys;
		chk(disp_text, BLANK);
		key(5'h01);
		key(5'h02);
		chk(disp_text, {"        ", "      12"});
		chk(disp_level, {{8{fpmd_pkg::LVL_HALF}}, {8{fpmd_pkg::LVL_DIM}}});
		key(fpmd_pkg::KEY_ENTER);
		chk(disp_text[127:64], "STORED  ");
		chk(disp_level, HALF);
		key(fpmd_pkg::KEY_ENTER);
		chk(disp_text[127:64], "ENTERED ");
		key(fpmd_pkg::KEY_SET);
		chk(disp_text[127:64], "SET     ");
		key(5'h05);
		key(fpmd_pkg::KEY_POINT);
		chk(disp_text, {"SET     ", "      5."});
		key(fpmd_pkg::KEY_CLEAR);
		chk(disp_text, {"SET     ", "        "});
		key(fpmd_pkg::KEY_CLEAR);
		chk(disp_text, BLANK);
		key(fpmd_pkg::KEY_DASH);
		step(40);
		chk(disp_text[127:64], "SPARE   ");
		step(15);
		chk(disp_text, BLANK);
		$display("key test done");
	endtask
	task t_trip;
		trip_event = 1'b1;
		step(1);
		trip_event = 1'b0;
		step(1);
		chk(disp_text, TRIP_LINE);
		chk(disp_level, {16{fpmd_pkg::LVL_MAX}});
		chk(nv_trip_valid, 1'b1);
		step(int'(BLK) + 4);
		chk(disp_level, {{fpmd_pkg::TRIP_WORD_CHARS{fpmd_pkg::LVL_OFF}}, {12{fpmd_pkg::LVL_MAX}}});
		step(int'(TMO) + 10);
		chk(disp_text, TRIP_LINE);
		restart;
		chk(disp_text, TRIP_LINE);
		key(fpmd_pkg::KEY_UP);
		chk(disp_text, BLANK);
		chk(nv_trip_valid, 1'b0);
		restart;
		chk(disp_text, BLANK);
		$display("trip test done");
	endtask
	task t_notices;
		fail_event = 1'b1;
		step(1);
		fail_event = 1'b0;
		step(1);
		chk(disp_text, "FAIL 042        ");
		chk(disp_level, HALF);
		step(int'(TMO) + 10);
		chk(disp_text[127:96], "FAIL");
		key(fpmd_pkg::KEY_UP);
		chk(disp_text, BLANK);
		warn_event = 1'b1;
		step(1);
		warn_event = 1'b0;
		step(1);
		chk(disp_text, "WARN 007        ");
		restart;
		chk(disp_text, BLANK);
		$display("notice test done");
	endtask
	task stop_test;
		$display("checks %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// whole run is about 270 clocks; the limit is far beyond
	initial begin
		#200000;
		n_errors++;
		stop_test;
	end
	initial begin
		restart;
		t_keys;
		t_trip;
		t_notices;
		stop_test;
	end
endmodule // test_fpmd_display
